// File: include/floppy_status_rate_map.svh
/*
 Offsets, field positions, reset values and codes of the floppy status and rate register slice.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef FLOPPY_STATUS_RATE_MAP_SVH
`define FLOPPY_STATUS_RATE_MAP_SVH

`define OFS_DIGITAL_OUTPUT    3'h2
`define OFS_TAPE_SELECT       3'h3
`define OFS_MAIN_STATUS       3'h4
`define OFS_RATE_SELECT       3'h4
`define OFS_DATA              3'h5
`define OFS_DISKETTE_CONTROL  3'h7

`define RATE_SELECT_RESET     8'h02
`define RATE_RESET_BIT        7
`define RATE_POWER_BIT        6
`define PRECOMP_HI            4
`define PRECOMP_LO            2
`define DOR_RESET_BIT         2

`define RATE_500K             2'h0
`define RATE_300K             2'h1
`define RATE_250K             2'h2
`define RATE_1M               2'h3

`define PRECOMP_DEFAULT_CODE  3'h0
`define PRECOMP_ZERO_CODE     3'h7
`define PRECOMP_STEP_PS       41667
`define PRECOMP_DEF_1M        3'h1
`define PRECOMP_DEF_OTHER     3'h3

`endif

// File: include/floppy_status_rate_pkg.sv
/*
 Types shared by the floppy status and rate register slice.
 Assumes the map header sits on the include path.
*/
`include "floppy_status_rate_map.svh"

package floppy_status_rate_pkg;

   typedef struct packed {
      logic       host_request;
      logic       transfer_direction;
      logic       non_dma_flag;
      logic       command_busy;
      logic       drive_b_seeking;
      logic       drive_a_seeking;
   } core_status_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } host_req_t;

   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_DOWN
   } power_state_t;

endpackage : floppy_status_rate_pkg

// File: src/floppy_status_rate_registers.sv
/*
 Tape select, main status and rate select registers of a floppy controller host port.
 Assumes a plain register port on clk_i, and core status from logic on the same clock.
*/
// Strobed register access was decided locally.
// Operation
// RQ1 - Tape select readable, writable, no internal effect
// RQ2 - Host polls status before each non-DMA byte
// RQ3 - Status bit 7 shows ready for byte
// RQ4 - Status bit 6 shows transfer direction
// RQ5 - Status bit 5 shows non-DMA mode
// RQ6 - Status bit 4 shows command in progress
// RQ7 - Status bits 1-0 show drive seeking
// RQ8 - Rate select write-only, shares status offset
// RQ9 - Active rate follows last rate write
// RQ10 - Software reset leaves rate select alone
// RQ11 - Hardware reset loads rate select 02h
// RQ12 - Rate bit 7 resets core, self-clears
// RQ13 - Rate bit 6 stops clocks until wake
// RQ14 - Rate bits 4-2 pick precompensation delay
// RQ15 - Rate bits 1-0 pick data rate
// RQ16 - Output register reset is active low
// RQ17 - Diskette control carries same rate field
// RQ18 - Offset 04h reads status, writes rate
`include "floppy_status_rate_map.svh"

module floppy_status_rate_registers
(
   input  wire logic                                 clk_i,
   input  wire logic                                 reset_i,
   input  wire floppy_status_rate_pkg::host_req_t    req_i,
   output logic       [7:0]                          rdata_o,
   input  wire floppy_status_rate_pkg::core_status_t core_status_i,
   input  wire logic                                 dor_reset_n_i,
   output logic                                      core_reset_o,
   output logic                                      clocks_stopped_o,
   output logic       [1:0]                          rate_code_o,
   output logic       [2:0]                          precomp_steps_o,
   output logic       [1:0]                          tape_drive_choice_o
);

   logic [7:0]                         tape_select_ff;
   logic [7:0]                         rate_select_ff;
   logic [1:0]                         rate_code_ff;
   logic                               sw_reset_ff;
   floppy_status_rate_pkg::power_state_t power_ff;
   logic [7:0]                         nxt_rdata;
   logic [2:0]                         nxt_precomp;
   logic                               wr_rate;
   logic                               wr_dcr;
   logic                               wake;

   function automatic logic [2:0] precomp_of(input logic [2:0] code, input logic [1:0] rate);
      logic [2:0] steps;
      steps = code;
      if (code == `PRECOMP_ZERO_CODE)
      begin
         steps = 3'h0;
      end
      else if (code == `PRECOMP_DEFAULT_CODE)
      begin
         steps = (rate == `RATE_1M) ? `PRECOMP_DEF_1M : `PRECOMP_DEF_OTHER;
      end
      return steps;
   endfunction : precomp_of

   function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
      return a == ofs;
   endfunction : hit

   assign wr_rate = req_i.wr && hit(req_i.addr, `OFS_RATE_SELECT); // RQ8
   assign wr_dcr  = req_i.wr && hit(req_i.addr, `OFS_DISKETTE_CONTROL); // RQ17
   assign wake    = (req_i.rd && hit(req_i.addr, `OFS_MAIN_STATUS))
                    || ((req_i.rd || req_i.wr) && hit(req_i.addr, `OFS_DATA)); // RQ13 RQ18

   // Tape select bits 1-0 are stored, read back and driven on tape_drive_choice_o.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         tape_select_ff <= 8'h00;
      end
      else if (req_i.wr && hit(req_i.addr, `OFS_TAPE_SELECT))
      begin
         tape_select_ff <= {6'h00, req_i.wdata[1:0]}; // RQ1
      end
   end

   // Rate select holds its value across a software reset.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rate_select_ff <= `RATE_SELECT_RESET; // RQ11
      end
      else if (wr_rate)
      begin
         rate_select_ff <= {1'b0, req_i.wdata[6:0]}; // RQ10
      end
   end

   // The last write of either register sets the active rate.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rate_code_ff <= 2'(`RATE_SELECT_RESET); // RQ11
      end
      else if (wr_rate || wr_dcr)
      begin
         rate_code_ff <= req_i.wdata[1:0]; // RQ9 RQ15
      end
   end

   // The reset bit is a one-cycle pulse, it clears itself.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         sw_reset_ff <= 1'b0;
      end
      else
      begin
         sw_reset_ff <= wr_rate && req_i.wdata[`RATE_RESET_BIT]; // RQ12
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         core_reset_o <= 1'b1;
      end
      else
      begin
         core_reset_o <= !dor_reset_n_i || sw_reset_ff; // RQ16 RQ12
      end
   end

   // Power down stops the clocks until a wake access, a software reset or an output register reset.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         power_ff <= floppy_status_rate_pkg::PWR_RUN;
      end
      else
      begin
         case (power_ff)
            floppy_status_rate_pkg::PWR_RUN:
            begin
               if (wr_rate && req_i.wdata[`RATE_POWER_BIT] && !req_i.wdata[`RATE_RESET_BIT])
               begin
                  power_ff <= floppy_status_rate_pkg::PWR_DOWN; // RQ13
               end
            end
            default:
            begin
               if (wake || sw_reset_ff || !dor_reset_n_i)
               begin
                  power_ff <= floppy_status_rate_pkg::PWR_RUN; // RQ13
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         clocks_stopped_o <= 1'b0;
      end
      else
      begin
         clocks_stopped_o <= (power_ff == floppy_status_rate_pkg::PWR_DOWN);
      end
   end

   always_comb
   begin
      nxt_precomp = precomp_of(rate_select_ff[`PRECOMP_HI:`PRECOMP_LO], rate_code_ff); // RQ14
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rate_code_o         <= 2'(`RATE_SELECT_RESET);
         precomp_steps_o     <= `PRECOMP_DEF_OTHER;
         tape_drive_choice_o <= 2'h0;
      end
      else
      begin
         rate_code_o         <= rate_code_ff;
         precomp_steps_o     <= nxt_precomp;
         tape_drive_choice_o <= tape_select_ff[1:0];
      end
   end

   // Read decode; a read at the shared offset returns the status only.
   always_comb
   begin
      nxt_rdata = 8'h00;
      if (hit(req_i.addr, `OFS_TAPE_SELECT))
      begin
         nxt_rdata = tape_select_ff; // RQ1
      end
      else if (hit(req_i.addr, `OFS_MAIN_STATUS))
      begin
         nxt_rdata = {core_status_i.host_request, // RQ3
                      core_status_i.transfer_direction, // RQ4
                      core_status_i.non_dma_flag, // RQ5
                      core_status_i.command_busy, // RQ6
                      2'b00,
                      core_status_i.drive_b_seeking, // RQ7
                      core_status_i.drive_a_seeking}; // RQ18
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (req_i.rd)
      begin
         rdata_o <= nxt_rdata; // RQ2
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

   a_reset_pulse_once: assert property (@(posedge clk_i) disable iff (reset_i) // RQ12
      sw_reset_ff |=> !sw_reset_ff)
      else $error("software reset bit did not clear itself");

   a_reset_reaches_core: assert property (@(posedge clk_i) disable iff (reset_i) // RQ12
      (wr_rate && req_i.wdata[7]) |=> ##1 core_reset_o)
      else $error("rate reset bit did not reset the core");

   a_rate_follows_write: assert property (@(posedge clk_i) disable iff (reset_i) // RQ9
      (wr_rate || wr_dcr) |=> ##1 (rate_code_o == $past(req_i.wdata[1:0], 2)))
      else $error("active rate does not follow the last write");

   a_status_read_back: assert property (@(posedge clk_i) disable iff (reset_i) // RQ3
      (req_i.rd && req_i.addr == 3'h4) |=> (rdata_o[7] == $past(core_status_i.host_request)
         && rdata_o[3:2] == 2'b00 && rdata_o[0] == $past(core_status_i.drive_a_seeking)))
      else $error("status read data wrong");

   a_tape_read_back: assert property (@(posedge clk_i) disable iff (reset_i) // RQ1
      (req_i.wr && req_i.addr == 3'h3) ##1 (req_i.rd && req_i.addr == 3'h3)
         |=> rdata_o[1:0] == $past(req_i.wdata[1:0], 2))
      else $error("tape select did not read back");

   a_power_down_entry: assert property (@(posedge clk_i) disable iff (reset_i) // RQ13
      (wr_rate && req_i.wdata[7:6] == 2'b01) |=> ##1 clocks_stopped_o)
      else $error("power down did not stop clocks");

   a_power_wakeup: assert property (@(posedge clk_i) disable iff (reset_i) // RQ13
      (power_ff == floppy_status_rate_pkg::PWR_DOWN && wake) |=> ##1 !clocks_stopped_o)
      else $error("access did not wake the clocks");

   a_precomp_default: assert property (@(posedge clk_i) disable iff (reset_i) // RQ14
      (rate_select_ff[4:2] == 3'h0 && rate_code_ff == 2'h3) |=> precomp_steps_o == 3'h1)
      else $error("default precompensation wrong at top rate");

   a_dor_reset_core: assert property (@(posedge clk_i) disable iff (reset_i) // RQ16
      !dor_reset_n_i |=> core_reset_o && $stable(rate_select_ff))
      else $error("output register reset misbehaved");

   a_status_direction: assert property (@(posedge clk_i) disable iff (reset_i) // RQ4
      (req_i.rd && req_i.addr == 3'h4)
         |=> rdata_o[6] == $past(core_status_i.transfer_direction))
      else $error("status direction bit wrong");

   a_status_dma_mode: assert property (@(posedge clk_i) disable iff (reset_i) // RQ5
      (req_i.rd && req_i.addr == 3'h4)
         |=> rdata_o[5] == $past(core_status_i.non_dma_flag))
      else $error("status non-DMA bit wrong");

   a_status_cmd_busy: assert property (@(posedge clk_i) disable iff (reset_i) // RQ6
      (req_i.rd && req_i.addr == 3'h4)
         |=> rdata_o[4] == $past(core_status_i.command_busy))
      else $error("status command busy bit wrong");

   a_status_drive_b: assert property (@(posedge clk_i) disable iff (reset_i) // RQ7
      (req_i.rd && req_i.addr == 3'h4)
         |=> rdata_o[1] == $past(core_status_i.drive_b_seeking))
      else $error("status drive B seek bit wrong");

   a_idle_read_zero: assert property (@(posedge clk_i) disable iff (reset_i) // RQ18
      !req_i.rd |=> rdata_o == 8'h00)
      else $error("read data did not return to zero");

   a_rate_select_store: assert property (@(posedge clk_i) disable iff (reset_i) // RQ8
      wr_rate |=> rate_select_ff == {1'b0, $past(req_i.wdata[6:0])})
      else $error("rate select write not stored");

   a_rate_select_held: assert property (@(posedge clk_i) disable iff (reset_i) // RQ10
      !wr_rate |=> $stable(rate_select_ff))
      else $error("rate select changed without a write");

   a_hw_reset_values: assert property (@(posedge clk_i) disable iff (reset_i) // RQ11
      $fell(reset_i) |-> rate_select_ff == 8'h02 && rate_code_o == 2'h2
         && precomp_steps_o == 3'h3 && core_reset_o && !clocks_stopped_o)
      else $error("hardware reset values wrong");

   a_precomp_explicit: assert property (@(posedge clk_i) disable iff (reset_i) // RQ14
      (rate_select_ff[4:2] != 3'h0 && rate_select_ff[4:2] != 3'h7)
         |=> precomp_steps_o == $past(rate_select_ff[4:2]))
      else $error("explicit precompensation wrong");

   a_precomp_zero: assert property (@(posedge clk_i) disable iff (reset_i) // RQ14
      rate_select_ff[4:2] == 3'h7 |=> precomp_steps_o == 3'h0)
      else $error("zero precompensation wrong");

   a_precomp_slow_default: assert property (@(posedge clk_i) disable iff (reset_i) // RQ14
      (rate_select_ff[4:2] == 3'h0 && rate_code_ff != 2'h3) |=> precomp_steps_o == 3'h3)
      else $error("default precompensation wrong at slow rates");

   a_tape_no_effect: assert property (@(posedge clk_i) disable iff (reset_i) // RQ1
      (req_i.wr && req_i.addr == 3'h3)
         |=> $stable(rate_select_ff) && $stable(rate_code_ff))
      else $error("tape select write disturbed the rate");

   a_dcr_rate_only: assert property (@(posedge clk_i) disable iff (reset_i) // RQ17
      wr_dcr
         |=> rate_code_ff == $past(req_i.wdata[1:0]) && $stable(rate_select_ff))
      else $error("diskette control write wrong");

   a_core_reset_release: assert property (@(posedge clk_i) disable iff (reset_i) // RQ16
      (dor_reset_n_i && !sw_reset_ff) |=> !core_reset_o)
      else $error("core reset held without a cause");

   a_reset_blocks_power: assert property (@(posedge clk_i) disable iff (reset_i) // RQ12
      (wr_rate && req_i.wdata[7] && power_ff == floppy_status_rate_pkg::PWR_RUN)
         |=> power_ff == floppy_status_rate_pkg::PWR_RUN)
      else $error("power down entered during a software reset");

   a_power_stays_down: assert property (@(posedge clk_i) disable iff (reset_i) // RQ13
      (power_ff == floppy_status_rate_pkg::PWR_DOWN && !wake && !sw_reset_ff
         && dor_reset_n_i) |=> power_ff == floppy_status_rate_pkg::PWR_DOWN)
      else $error("power down left without a wake event");

endmodule : floppy_status_rate_registers

// File: tb/core_status_model.sv
/*
 Model of the controller core that feeds status levels to the register slice.
 Assumes the bench changes the pattern just after a rising edge.
*/
module core_status_model
(
   input  wire logic                            clk_i,
   input  wire logic                            reset_i,
   input  wire logic [5:0]                      pattern_i,
   output floppy_status_rate_pkg::core_status_t status_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Status levels change only on the shared clock, as the core's would.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         status_o <= '0;
      end
      else
      begin
         status_o <= pattern_i;
      end
   end
endmodule : core_status_model

// File: tb/floppy_status_rate_registers_tb_top.sv
/*
 Self-checking bench for the floppy status and rate register slice.
 Assumes the package, the map header and the core status model are compiled first.
*/
module floppy_status_rate_registers_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic                                 clk_i       = 1'b0;
   logic                                 reset_i     = 1'b1;
   floppy_status_rate_pkg::host_req_t    req         = '0;
   floppy_status_rate_pkg::core_status_t status;
   logic [5:0]                           pattern     = '0;
   logic                                 dor_reset_n = 1'b1;
   logic [7:0]                           rdata;
   logic [7:0]                           got;
   logic                                 core_reset;
   logic                                 stopped;
   logic [1:0]                           rate;
   logic [1:0]                           tape;
   logic [2:0]                           precomp;
   logic [31:0]                          r           = 32'he73e;
   int                                   n_fail      = 0;
   int                                   checked     = 0;

   always #20 clk_i = ~clk_i;

   core_status_model u_core_status_model
   (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .pattern_i (pattern),
      .status_o  (status)
   );

   floppy_status_rate_registers u_floppy_status_rate_registers
   (
      .clk_i               (clk_i),
      .reset_i             (reset_i),
      .req_i               (req),
      .rdata_o             (rdata),
      .core_status_i       (status),
      .dor_reset_n_i       (dor_reset_n),
      .core_reset_o        (core_reset),
      .clocks_stopped_o    (stopped),
      .rate_code_o         (rate),
      .precomp_steps_o     (precomp),
      .tape_drive_choice_o (tape)
   );

   function logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
   endfunction : lfsr

   // Precompensation steps of 41.7 ns expected for a code at a rate.
   function logic [2:0] exp_pre(input logic [2:0] c, input logic [1:0] rt);
      if (c == 3'h7)
         return 3'h0;
      if (c == 3'h0)
         return (rt == 2'h3) ? 3'h1 : 3'h3;
      return c;
   endfunction : exp_pre

   task report_and_stop;
      $display("checks %0d, failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checked++;
      if (seen !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
         n_fail++;
      end
   endtask : chk

   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req.wr <= 1'b0;
   endtask : wr

   task rd(input logic [2:0] a);
      @(posedge clk_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req.rd <= 1'b0;
      #1 got = rdata;
   endtask : rd

   // Write then read at once, with no idle cycle between the strobes.
   task wr_then_rd(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req.rd <= 1'b0;
      #1 got = rdata;
   endtask : wr_then_rd

   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   initial
   begin
      repeat (3000) @(posedge clk_i);
      n_fail++;
      report_and_stop();
   end

   initial
   begin
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      tick(2);
      chk("rate", 8'h02, {6'h0, rate});
      chk("precomp", 8'h03, {5'h0, precomp});
      chk("core reset", 8'h00, {7'h0, core_reset});
      $display("test reset done");
      for (int i = 0; i < 20; i++)
      begin
         r = lfsr(r);
         wr_then_rd(3'h3, r[7:0]);
         chk("tape", {6'h0, r[1:0]}, got);
         chk("tape out", {6'h0, r[1:0]}, {6'h0, tape});
         @(posedge clk_i);
         pattern <= r[13:8];
         rd(3'h4);
         chk("status", {r[13:10], 2'b00, r[9:8]}, got);
         tick(1);
         chk("rdata idle", 8'h00, rdata);
         rd(3'h6);
         chk("unmapped", 8'h00, got);
         wr(3'h4, {2'b00, r[5], i[2:0], r[17:16]});
         tick(1);
         chk("rate", {6'h0, r[17:16]}, {6'h0, rate});
         chk("precomp", {5'h0, exp_pre(i[2:0], r[17:16])}, {5'h0, precomp});
         wr(3'h7, {6'h0, r[19:18]});
         tick(1);
         chk("rate", {6'h0, r[19:18]}, {6'h0, rate});
      end
      $display("test random traffic done");
      wr(3'h4, 8'h0d);
      wr(3'h4, 8'h99);
      tick(1);
      chk("core reset", 8'h01, {7'h0, core_reset});
      tick(1);
      chk("core reset", 8'h00, {7'h0, core_reset});
      chk("rate", 8'h01, {6'h0, rate});
      chk("precomp", 8'h06, {5'h0, precomp});
      wr(3'h4, 8'h4d);
      tick(1);
      chk("stopped", 8'h01, {7'h0, stopped});
      wr(3'h4, 8'h4d);
      tick(1);
      chk("stopped", 8'h01, {7'h0, stopped});
      rd(3'h4);
      tick(2);
      chk("stopped", 8'h00, {7'h0, stopped});
      wr(3'h4, 8'h4d);
      wr(3'h5, 8'h5a);
      tick(2);
      chk("stopped", 8'h00, {7'h0, stopped});
      $display("test rate reset and power done");
      wr(3'h4, 8'h4d);
      tick(1);
      @(posedge clk_i);
      dor_reset_n <= 1'b0;
      tick(2);
      chk("core reset", 8'h01, {7'h0, core_reset});
      chk("stopped", 8'h00, {7'h0, stopped});
      chk("rate", 8'h01, {6'h0, rate});
      chk("precomp", 8'h03, {5'h0, precomp});
      @(posedge clk_i);
      dor_reset_n <= 1'b1;
      tick(2);
      chk("core reset", 8'h00, {7'h0, core_reset});
      $display("test output reset done");
      wr(3'h4, 8'h1b);
      wr(3'h3, 8'h02);
      @(posedge clk_i);
      reset_i <= 1'b1;
      tick(2);
      chk("core reset", 8'h01, {7'h0, core_reset});
      @(posedge clk_i);
      reset_i <= 1'b0;
      tick(2);
      chk("rate", 8'h02, {6'h0, rate});
      chk("precomp", 8'h03, {5'h0, precomp});
      chk("tape out", 8'h00, {6'h0, tape});
      chk("core reset", 8'h00, {7'h0, core_reset});
      $display("test hardware reset done");
      report_and_stop();
   end
endmodule : floppy_status_rate_registers_tb_top
